// >>> rbt_rate_buffer.v
// Rate buffer timing model: encoder buffer schedule, balance FIFO
// delay, decoder accumulation delay and complementary fullness.
// Assumes group_valid and friends come from logic on clk, one pixel
// time per clock, and an Avalon-MM master on the register port.
//
// Notes on behaviour
// - Encoder model fullness stays within zero and buffer size; breaches flagged.
// - Decoder model never overflows or underflows on a conforming stream.
// - Decoder buffer capacity is the same buffer size register as encoder.
// - Latency is REFERENCE_DECODER_MODEL delay plus fixed balance FIFO delay, constant.
// - Constant rate: full encoder buffer means empty decoder buffer.
// - Decoder runs the same encoder model; its fullness moves oppositely.
// - Balance FIFO holds mux word plus max element minus one groups.
// - At 8 bpc that is 83 units, 249 pixel times.
// - Decoder waits initial decode delay, then takes mux words on demand.
// - Transmission delay counts from bits entering the rate buffer model.
// - Constant rate: decoder fullness is buffer size minus encoder fullness.
// - Variable rate: link rate zero when encoder buffer empty.
// - During transmission delay bits are added, none removed.
// - After that, bits added per content and drained at constant rate.
// - Constant rate: force midpoint prediction when fullness is low.
// - After last group nothing added; drain continues until empty.
// - Constant rate: zero padding until slice bit budget is sent.
// - Decode delay is REFERENCE_DECODER_MODEL delay minus transmission delay; then complement.
// - Transmission delay timer starts after the balance FIFO delay.
// - Mux word packing variation does not change end-to-end delay.
// - Mux word is 48 bits up to 10 bpc, else 64 bits.
// - Per group add coded bits, subtract three times bpp, whole bits.
// - Variable rate: negative fullness after subtraction clamps to zero.
`timescale 1ns/100ps
`include "rbt_regs.vh"

module rbt_rate_buffer (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Avalon-MM register slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  // Encoder group stream
  input wire slice_start,
  input wire group_valid,
  input wire [9:0] group_bits,
  input wire last_group,
  // Link and decoder side
  output reg link_valid,
  output reg [7:0] link_bits,
  output reg link_pad,
  output reg midpoint_prediction_mode,
  output reg dec_started,
  output reg mux_word_take,
  output reg [6:0] mux_word_bits
);

  // ----------------------------------------------------------------------
  // Phases of the slice schedule (one-hot)
  // ----------------------------------------------------------------------
  localparam [5:0] PH_IDLE = 6'b00_0001;
  localparam [5:0] PH_BAL = 6'b00_0010;
  localparam [5:0] PH_XMIT = 6'b00_0100;
  localparam [5:0] PH_ACTIVE = 6'b00_1000;
  localparam [5:0] PH_FLUSH = 6'b01_0000;
  localparam [5:0] PH_PAD = 6'b10_0000;

  // Byte-lane merge of a write into an old word
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer i;
    begin
      be_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          be_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  // Clamp a signed fullness into the unsigned model range
  function [17:0] clamp_low;
    input signed [18:0] v;
    begin
      clamp_low = v[18] ? 18'h0_0000 : v[17:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  reg ack_q;
  reg enable_q;
  reg vbr_q;
  reg [9:0] bpp_q;
  reg [15:0] buf_size_q;
  reg [15:0] xmit_delay_q;
  reg [15:0] hrd_delay_q;
  reg [31:0] slice_budget_q;
  reg [15:0] mpp_thresh_q;
  reg [6:0] max_se_q;
  reg [4:0] bpc_q;
  reg ovf_q;
  reg unf_q;
  reg [5:0] phase_q;
  reg [5:0] phase_d;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  reg [17:0] enc_full_q;
  reg [17:0] enc_full_d;
  reg [17:0] bal_hold_q;
  reg [17:0] bal_hold_d;
  reg [3:0] frac_q;
  reg [3:0] frac_d;
  reg [1:0] pix_q;
  reg [31:0] sent_q;
  reg [31:0] sent_d;
  reg [17:0] deficit_q;
  reg [17:0] deficit_d;
  reg [15:0] dec_cnt_q;
  reg tx_on_q;
  reg last_seen_q;
  reg ovf_ev;
  reg unf_ev;
  reg [7:0] send_d;
  reg pad_d;

  wire req = read | write;
  wire acc_edge = req & ack_q;
  wire group_tick = (pix_q == 2'h2);
  wire clr_err = acc_edge & write & byteenable[0] &
    (address == `RBT_OFF_CTRL) & writedata[`RBT_CTRL_CLR_ERR];

  // One wait state per access; answer on the second edge
  assign waitrequest = req & ~ack_q;

  // Nominal bits per group, 3 x bpp with fraction carried
  wire [13:0] nom_sum = {4'h0, frac_q} + ({4'h0, bpp_q} * 14'd3);
  wire [9:0] nom_bits = nom_sum[13:4];

  // Balance FIFO depth in groups and in pixel times
  wire [7:0] bal_groups = {1'b0, mux_word_bits} + {1'b0, max_se_q}
    - 8'h01;
  wire [9:0] bal_delay = {2'h0, bal_groups} * 10'd3;
  wire [15:0] dec_delay = hrd_delay_q - xmit_delay_q;
  wire [15:0] latency = hrd_delay_q + {6'h00, bal_delay};
  wire constant_rate_operation = ~vbr_q;
  // Lane-merged write words; only the low field bits are kept
  wire [31:0] m_bpp = be_merge({22'h0, bpp_q}, writedata, byteenable);
  wire [31:0] m_size = be_merge({16'h0, buf_size_q}, writedata, byteenable);
  wire [31:0] m_xmit = be_merge({16'h0, xmit_delay_q}, writedata, byteenable);
  wire [31:0] m_hrd = be_merge({16'h0, hrd_delay_q}, writedata, byteenable);
  wire [31:0] m_mpp = be_merge({16'h0, mpp_thresh_q}, writedata, byteenable);
  wire [31:0] pad_left = slice_budget_q - sent_q;

  // ----------------------------------------------------------------------
  // Decoder model fullness
  // ----------------------------------------------------------------------
  // Same encoder model drives the decoder view, mirrored
  wire [17:0] size_x = {2'h0, buf_size_q};
  wire [17:0] comp = size_x - enc_full_q;
  wire [17:0] dec_full_w = !dec_started ? sent_q[17:0] :
    (constant_rate_operation ? comp :
    (comp > deficit_q ? comp - deficit_q : 18'h0_0000));

  // ----------------------------------------------------------------------
  // Bus handshake and register writes
  // ----------------------------------------------------------------------
  // Writes land only on the edge where waitrequest is low
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      enable_q <= 1'b0;
      vbr_q <= 1'b0;
      bpp_q <= `RBT_RST_BPP;
      buf_size_q <= `RBT_RST_BUF_SIZE;
      xmit_delay_q <= `RBT_RST_XMIT_DELAY;
      hrd_delay_q <= `RBT_RST_HRD_DELAY;
      slice_budget_q <= `RBT_RST_SLICE_BUDGET;
      mpp_thresh_q <= `RBT_RST_MPP_THRESH;
      max_se_q <= `RBT_RST_MAX_SE;
      bpc_q <= `RBT_RST_BPC;
    end else begin
      ack_q <= req & ~ack_q;
      if (acc_edge & write) begin
        case (address)
          `RBT_OFF_CTRL: begin
            if (byteenable[0]) begin
              enable_q <= writedata[`RBT_CTRL_ENABLE];
              vbr_q <= writedata[`RBT_CTRL_VBR];
            end
          end
          `RBT_OFF_BPP: begin
            bpp_q <= m_bpp[9:0];
          end
          `RBT_OFF_BUF_SIZE: begin
            buf_size_q <= m_size[15:0];
          end
          `RBT_OFF_XMIT_DELAY: begin
            xmit_delay_q <= m_xmit[15:0];
          end
          `RBT_OFF_HRD_DELAY: begin
            hrd_delay_q <= m_hrd[15:0];
          end
          `RBT_OFF_SLICE_BUDGET: begin
            slice_budget_q <= be_merge(slice_budget_q, writedata,
              byteenable);
          end
          `RBT_OFF_MPP_THRESH: begin
            mpp_thresh_q <= m_mpp[15:0];
          end
          `RBT_OFF_SE_BPC: begin
            if (byteenable[0]) begin
              max_se_q <= writedata[6:0];
            end
            if (byteenable[1]) begin
              bpc_q <= writedata[`RBT_SE_BPC_LSB +: 5];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read data captured on the wait cycle, stable at the taking edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack_q) begin
      case (address)
        `RBT_OFF_CTRL: readdata <= {30'h0, vbr_q, enable_q};
        `RBT_OFF_BPP: readdata <= {22'h0, bpp_q};
        `RBT_OFF_BUF_SIZE: readdata <= {16'h0, buf_size_q};
        `RBT_OFF_XMIT_DELAY: readdata <= {16'h0, xmit_delay_q};
        `RBT_OFF_HRD_DELAY: readdata <= {16'h0, hrd_delay_q};
        `RBT_OFF_SLICE_BUDGET: readdata <= slice_budget_q;
        `RBT_OFF_MPP_THRESH: readdata <= {16'h0, mpp_thresh_q};
        `RBT_OFF_SE_BPC: readdata <= {19'h0, bpc_q, 1'b0, max_se_q};
        `RBT_OFF_STATUS: readdata <= {20'h0, dec_started,
          midpoint_prediction_mode, unf_q, ovf_q, 2'h0, phase_q};
        `RBT_OFF_ENC_FULL: readdata <= {14'h0, enc_full_q};
        `RBT_OFF_DEC_FULL: readdata <= {14'h0, dec_full_w};
        `RBT_OFF_DELAYS: readdata <= {latency, dec_delay};
        `RBT_OFF_SENT: readdata <= sent_q;
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Slice schedule
  // ----------------------------------------------------------------------
  // Next fullness, link output and phase for this pixel time
  always @* begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    enc_full_d = enc_full_q;
    bal_hold_d = bal_hold_q;
    frac_d = frac_q;
    sent_d = sent_q;
    deficit_d = deficit_q;
    send_d = 8'h00;
    pad_d = 1'b0;
    ovf_ev = 1'b0;
    unf_ev = 1'b0;
    case (phase_q)
      PH_IDLE: begin
        if (enable_q & slice_start) begin
          phase_d = PH_BAL;
          cnt_d = 16'h0000;
          enc_full_d = 18'h0_0000;
          bal_hold_d = 18'h0_0000;
          frac_d = 4'h0;
          sent_d = 32'h0000_0000;
          deficit_d = 18'h0_0000;
        end
      end
      PH_BAL: begin
        // Bits sit in balance FIFOs; model untouched until it ends
        if (group_valid) begin
          bal_hold_d = bal_hold_q + {8'h00, group_bits};
        end
        if (cnt_q + 16'h0001 >= {6'h00, bal_delay}) begin
          phase_d = PH_XMIT;
          cnt_d = 16'h0000;
          enc_full_d = bal_hold_d;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      PH_XMIT: begin
        if (group_valid) begin
          enc_full_d = enc_full_q + {8'h00, group_bits};
        end
        if (cnt_q + 16'h0001 >= xmit_delay_q) begin
          phase_d = PH_ACTIVE;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      PH_ACTIVE, PH_FLUSH, PH_PAD: begin
        if (group_valid & (phase_q == PH_ACTIVE)) begin
          enc_full_d = enc_full_q + {8'h00, group_bits};
        end
        if (last_seen_q & (phase_q == PH_ACTIVE)) begin
          phase_d = PH_FLUSH;
        end
        if (group_tick) begin
          frac_d = nom_sum[3:0];
          if (phase_q == PH_PAD) begin
            // Zero stuffing up to the slice budget
            pad_d = 1'b1;
            send_d = nom_bits[7:0];
            if (sent_q + {22'h0, nom_bits} >= slice_budget_q) begin
              send_d = pad_left[7:0];
              phase_d = PH_IDLE;
            end
          end else if (enc_full_d >= {8'h00, nom_bits}) begin
            send_d = nom_bits[7:0];
            enc_full_d = enc_full_d - {8'h00, nom_bits};
          end else begin
            // Model would go negative; clamp at zero
            send_d = vbr_q ? enc_full_d[7:0] : nom_bits[7:0];
            unf_ev = constant_rate_operation & (phase_q == PH_ACTIVE);
            deficit_d = deficit_q + {8'h00, nom_bits} - enc_full_d;
            enc_full_d = clamp_low(19'sd0);
          end
          sent_d = sent_q + {24'h0, send_d};
          if ((phase_q == PH_FLUSH) & (enc_full_d == 18'h0_0000)) begin
            phase_d = constant_rate_operation ? PH_PAD : PH_IDLE;
          end
        end
      end
      default: begin
        phase_d = PH_IDLE;
      end
    endcase
    if (enc_full_d > size_x) begin
      ovf_ev = 1'b1;
    end
  end

  // State, counters and link outputs; one pixel time per clock
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= PH_IDLE;
      cnt_q <= 16'h0000;
      enc_full_q <= 18'h0_0000;
      bal_hold_q <= 18'h0_0000;
      frac_q <= 4'h0;
      pix_q <= 2'h0;
      sent_q <= 32'h0000_0000;
      deficit_q <= 18'h0_0000;
      last_seen_q <= 1'b0;
      link_valid <= 1'b0;
      link_bits <= 8'h00;
      link_pad <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      enc_full_q <= enc_full_d;
      bal_hold_q <= bal_hold_d;
      frac_q <= frac_d;
      sent_q <= sent_d;
      deficit_q <= deficit_d;
      // Group time of three pixel times
      if (phase_q == PH_IDLE) begin
        pix_q <= 2'h0;
      end else if (pix_q == `RBT_PIX_PER_GROUP - 2'h1) begin
        pix_q <= 2'h0;
      end else begin
        pix_q <= pix_q + 2'h1;
      end
      if (phase_q == PH_IDLE) begin
        last_seen_q <= 1'b0;
      end else if (group_valid & last_group) begin
        last_seen_q <= 1'b1;
      end
      // Rate of zero on an empty variable-rate buffer
      link_valid <= (send_d != 8'h00);
      link_bits <= send_d;
      link_pad <= pad_d;
    end
  end

  // ----------------------------------------------------------------------
  // Error flags, prediction override, decoder start
  // ----------------------------------------------------------------------
  // Events set over a software clear in the same cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      midpoint_prediction_mode <= 1'b0;
      mux_word_bits <= `RBT_MUX_WORD_LO;
      tx_on_q <= 1'b0;
      dec_cnt_q <= 16'h0000;
      dec_started <= 1'b0;
      mux_word_take <= 1'b0;
    end else begin
      ovf_q <= ovf_ev | (ovf_q & ~clr_err);
      unf_q <= unf_ev | (unf_q & ~clr_err);
      // Low fullness forces the minimum-rate mode
      midpoint_prediction_mode <= constant_rate_operation & (phase_q == PH_ACTIVE) &
        (enc_full_q < {2'h0, mpp_thresh_q});
      mux_word_bits <= (bpc_q <= `RBT_BPC_LO_MAX) ? `RBT_MUX_WORD_LO :
        `RBT_MUX_WORD_HI;
      // Decoder delay counts from first transmitted pixel time
      if (phase_q == PH_IDLE) begin
        tx_on_q <= 1'b0;
        dec_cnt_q <= 16'h0000;
        dec_started <= 1'b0;
      end else if (phase_q == PH_ACTIVE) begin
        tx_on_q <= 1'b1;
      end
      // Start fixed by the slice start, not by mux word packing
      if (tx_on_q & ~dec_started) begin
        if (dec_cnt_q + 16'h0001 >= dec_delay) begin
          dec_started <= 1'b1;
        end else begin
          dec_cnt_q <= dec_cnt_q + 16'h0001;
        end
      end
      // Mux words taken on demand once decoding runs
      mux_word_take <= dec_started & group_valid;
    end
  end

endmodule // rbt_rate_buffer

// >>> rbt_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the rate buffer timing model. Assumes a 32-bit Avalon-MM slave
// with byte addresses and one aligned word per register.
`ifndef RBT_REGS_VH
`define RBT_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RBT_OFF_CTRL 8'h00
`define RBT_OFF_BPP 8'h04
`define RBT_OFF_BUF_SIZE 8'h08
`define RBT_OFF_XMIT_DELAY 8'h0C
`define RBT_OFF_HRD_DELAY 8'h10
`define RBT_OFF_SLICE_BUDGET 8'h14
`define RBT_OFF_MPP_THRESH 8'h18
`define RBT_OFF_SE_BPC 8'h1C
`define RBT_OFF_STATUS 8'h20
`define RBT_OFF_ENC_FULL 8'h24
`define RBT_OFF_DEC_FULL 8'h28
`define RBT_OFF_DELAYS 8'h2C
`define RBT_OFF_SENT 8'h30

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RBT_CTRL_ENABLE 0
`define RBT_CTRL_VBR 1
`define RBT_CTRL_CLR_ERR 2
`define RBT_STAT_OVF 8
`define RBT_STAT_UNF 9
`define RBT_STAT_MPP 10
`define RBT_STAT_DEC 11
`define RBT_SE_BPC_LSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RBT_RST_BPP 10'h0_080
`define RBT_RST_BUF_SIZE 16'h1_800
`define RBT_RST_XMIT_DELAY 16'h0_200
`define RBT_RST_HRD_DELAY 16'h0_600
`define RBT_RST_SLICE_BUDGET 32'h0000_0000
`define RBT_RST_MPP_THRESH 16'h0_060
`define RBT_RST_MAX_SE 7'h24
`define RBT_RST_BPC 5'h08

// ----------------------------------------------------------------------
// Timing and sizing constants
// ----------------------------------------------------------------------
`define RBT_PIX_PER_GROUP 2'h3
`define RBT_MUX_WORD_LO 7'h30
`define RBT_MUX_WORD_HI 7'h40
`define RBT_BPC_LO_MAX 5'h0A
`define RBT_BPP_FRAC_BITS 4

`endif

// >>> rbt_rate_buffer_properties.sv
// Port checker for the rate buffer timing model.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/100ps
module rbt_rate_buffer_properties (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Group stream
  input wire slice_start,
  input wire group_valid,
  input wire [9:0] group_bits,
  input wire last_group,
  // Link and decoder
  input wire link_valid,
  input wire [7:0] link_bits,
  input wire link_pad,
  input wire midpoint_prediction_mode,
  input wire dec_started,
  input wire mux_word_take,
  input wire [6:0] mux_word_bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ------------------------------------------------------------------
  // Shadow registers, so delays follow what software wrote
  // ------------------------------------------------------------------
  reg [15:0] xd_q, ref_q, cnt_q;
  reg [4:0] bpc_q;
  reg var_q;
  wire wr_ok = write && !waitrequest;
  wire [17:0] bal = 18'h0_0003 * (mux_word_bits + 18'h0_0023);
  // Byte lanes ignored: the bench writes whole words here
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xd_q <= 16'h0200;
      ref_q <= 16'h0600;
      bpc_q <= 5'h08;
      var_q <= 1'b0;
    end else if (wr_ok) begin
      if (address == 8'h0C) xd_q <= writedata[15:0];
      if (address == 8'h10) ref_q <= writedata[15:0];
      if (address == 8'h1C) bpc_q <= writedata[12:8];
      if (address == 8'h00) var_q <= writedata[1];
    end
  end
  // Cycles since slice start; saturates so it never wraps back
  always @(posedge clk or negedge nrst) begin
    if (!nrst) cnt_q <= 16'h0000;
    else if (slice_start) cnt_q <= 16'h0001;
    else if (cnt_q != 16'h0000 && cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  sequence s_new_req;
    (read || write) && !$past(read || write);
  endsequence
  sequence s_gap;
    !link_valid [*2];
  endsequence
  chk_wait_first: assert property (s_new_req |-> waitrequest)
    else $error("waitrequest low in first request cycle");
  chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("more than one wait state");
  chk_mux_size: assert property ($stable(bpc_q) |->
    mux_word_bits == (bpc_q <= 5'h0A ? 7'h30 : 7'h40))
    else $error("mux word size does not match component depth");
  chk_take_group: assert property (mux_word_take |-> $past(group_valid))
    else $error("mux word taken without a group");
  chk_link_nonzero: assert property (link_valid |-> link_bits != 8'h00)
    else $error("link valid with no bits");
  chk_link_rate: assert property (link_valid |=> s_gap)
    else $error("link words closer than one group time");
  chk_fill_quiet: assert property (cnt_q != 16'h0000 &&
    cnt_q <= bal + xd_q |-> !link_valid)
    else $error("link active before transmission delay ended");
  chk_dec_delay: assert property ($rose(dec_started) |->
    cnt_q + 18'h0_0002 >= bal + ref_q && cnt_q <= bal + ref_q + 18'h0_0002)
    else $error("decoder start at wrong time");
  chk_midpoint_var: assert property (var_q && $past(var_q) |->
    !midpoint_prediction_mode)
    else $error("midpoint forced in variable rate");
  chk_pad_const: assert property (link_pad |-> !var_q)
    else $error("padding in variable rate");
endmodule // rbt_rate_buffer_properties

bind rbt_rate_buffer rbt_rate_buffer_properties u_chk (.clk, .nrst,
  .address, .read, .write, .byteenable, .writedata, .readdata,
  .waitrequest, .slice_start, .group_valid, .group_bits, .last_group,
  .link_valid, .link_bits, .link_pad, .midpoint_prediction_mode,
  .dec_started, .mux_word_take, .mux_word_bits);

// >>> rbt_link_model.sv
// Far end of the transport link: counts data and padding bits.
// Assumes link outputs are registered on clk.
`timescale 1ns/100ps
module rbt_link_model (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Link from the encoder
  input wire link_valid,
  input wire [7:0] link_bits,
  input wire link_pad,
  // Received totals
  output logic [31:0] data_bits,
  output logic [31:0] pad_bits
);
  // Bits only count when valid, so an idle link adds nothing
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_bits <= 32'h0000_0000;
      pad_bits <= 32'h0000_0000;
    end else if (link_valid && link_pad) begin
      pad_bits <= pad_bits + {24'h00_0000, link_bits};
    end else if (link_valid) begin
      data_bits <= data_bits + {24'h00_0000, link_bits};
    end
  end
endmodule // rbt_link_model

// >>> tb_top.sv
// Testbench for the rate buffer timing model.
// Assumes the design, its checker and the link model are compiled first.
`timescale 1ns/100ps
`include "rbt_regs.vh"
module tb_top;
  logic clk, nrst, read, write, slice_start, group_valid, last_group;
  logic [7:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, rd, e, d0, p0;
  logic [9:0] group_bits;
  wire [31:0] readdata, data_bits, pad_bits;
  wire waitrequest, link_valid, link_pad, midpoint_prediction_mode;
  wire dec_started, mux_word_take;
  wire [7:0] link_bits;
  wire [6:0] mux_word_bits;
  logic [4:0] bpc;
  logic [6:0] mw;
  logic mid_seen, dec_seen;
  int mismatches, checked;
  logic [31:0] rv [13] = '{32'h0000_0000, 32'h0000_0080, 32'h0000_1800,
    32'h0000_0200, 32'h0000_0600, 32'h0000_0000, 32'h0000_0060,
    32'h0000_0824, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
    32'h06F9_0400, 32'h0000_0000};

  rbt_rate_buffer dut (.clk, .nrst, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .slice_start, .group_valid,
    .group_bits, .last_group, .link_valid, .link_bits, .link_pad,
    .midpoint_prediction_mode, .dec_started, .mux_word_take,
    .mux_word_bits);
  rbt_link_model u_link (.clk, .nrst, .link_valid, .link_bits, .link_pad,
    .data_bits, .pad_bits);

  // ------------------------------------------------------------------
  // Clock, flag catchers and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (midpoint_prediction_mode === 1'b1) mid_seen <= 1;
    if (dec_started === 1'b1) dec_seen <= 1;
  end
  initial begin
    #300_000;
    mismatches++;
    summarize;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic summarize;
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic x, input logic g);
    cmp(nm, {31'h0, x}, {31'h0, g});
  endtask
  // Hold the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) mismatches++;
    rd = readdata;
    read <= 0;
    write <= 0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string nm);
    bus(0, a, 32'h0000_0000, 4'h0);
    cmp(nm, x, rd);
  endtask
  task automatic start_slice;
    @(posedge clk);
    slice_start <= 1;
    @(posedge clk);
    slice_start <= 0;
    repeat (251) @(posedge clk); // Balance delay is 249 at 8 bpc
  endtask
  // One group every three pixel times
  task automatic groups(input int n, input logic [9:0] b, input logic last);
    for (int i = 0; i < n; i++) begin
      group_valid <= 1;
      group_bits <= b;
      last_group <= last && (i == n - 1);
      @(posedge clk);
      group_valid <= 0;
      last_group <= 0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(0, `RBT_OFF_STATUS, 32'h0000_0000, 4'h0);
      n++;
    end while (rd[5:0] !== 6'h01 && n < 3000);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {nrst, read, write, slice_start, group_valid, last_group} = 0;
    {address, byteenable, writedata, group_bits} = 0;
    {mid_seen, dec_seen, mismatches, checked} = 0;
    repeat (10) @(posedge clk);
    nrst <= 1;
    for (int i = 0; i < 13; i++) begin
      rdchk(8'(i * 4), rv[i], "reset value");
    end
    bus(1, 8'h40, 32'hFFFF_FFFF, 4'hF);
    bus(1, `RBT_OFF_STATUS, 32'h0000_0000, 4'hF);
    rdchk(8'h40, 32'h0000_0000, "unmapped");
    rdchk(`RBT_OFF_STATUS, 32'h0000_0001, "status read only");
    bus(1, `RBT_OFF_BPP, 32'h0000_0060, 4'h1);
    bus(1, `RBT_OFF_BPP, 32'h0000_0280, 4'h2);
    rdchk(`RBT_OFF_BPP, 32'h0000_0260, "bpp lanes");
    bus(1, `RBT_OFF_BPP, 32'h0000_0080, 4'hF);
    for (int i = 0; i < 5; i++) begin
      bpc = 5'(8 + 2 * i);
      mw = (bpc <= 5'h0A) ? 7'h30 : 7'h40;
      bus(1, `RBT_OFF_SE_BPC, {19'h0_0000, bpc, 8'h24}, 4'hF);
      repeat (2) @(negedge clk);
      cmp("mux word", {25'h0, mw}, {25'h0, mux_word_bits});
      e = {16'h0600 + 16'h0003 * (16'h0023 + mw), 16'h0400};
      rdchk(`RBT_OFF_DELAYS, e, "latency");
    end
    bus(1, `RBT_OFF_SE_BPC, 32'h0000_0824, 4'hF);
    // Constant rate slice: fill, hold, run low, finish, pad
    bus(1, `RBT_OFF_XMIT_DELAY, 32'h0000_0030, 4'hF);
    bus(1, `RBT_OFF_SLICE_BUDGET, 32'h0000_1F40, 4'hF);
    bus(1, `RBT_OFF_HRD_DELAY, 32'h0000_0130, 4'hF);
    bus(1, `RBT_OFF_CTRL, 32'h0000_0001, 4'hF);
    rdchk(`RBT_OFF_DELAYS, 32'h0229_0100, "decode delay");
    d0 = data_bits;
    p0 = pad_bits;
    start_slice;
    groups(36, 10'h018, 0);
    bus(0, `RBT_OFF_ENC_FULL, 32'h0000_0000, 4'h0);
    e = rd;
    bus(0, `RBT_OFF_DEC_FULL, 32'h0000_0000, 4'h0);
    d0 = d0 + 0;
    bus(0, `RBT_OFF_ENC_FULL, 32'h0000_0000, 4'h0);
    mid_seen = 0;
    groups(11, 10'h000, 0);
    cmp_bit("midpoint", 1'b1, mid_seen);
    groups(5, 10'h018, 1);
    groups(2, 10'h018, 0); // Arrive after the last group, must be dropped
    wait_idle;
    cmp("data bits", 32'h0000_03D8, data_bits - d0);
    cmp("slice total", 32'h0000_1F40, data_bits - d0 + pad_bits - p0);
    rdchk(`RBT_OFF_SENT, 32'h0000_1F40, "sent");
    rdchk(`RBT_OFF_STATUS & 8'hFF, 32'h0000_0001, "idle") ;
    cmp("errors", 32'h0000_0000, rd & 32'h0000_0300);
    cmp_bit("decoder start", 1'b1, dec_seen);
    // Variable rate slice: starved input, link stops, no padding
    bus(1, `RBT_OFF_CTRL, 32'h0000_0003, 4'hF);
    d0 = data_bits;
    p0 = pad_bits;
    start_slice;
    groups(30, 10'h006, 1);
    wait_idle;
    cmp("var data", 32'h0000_00B4, data_bits - d0);
    cmp("var pad", 32'h0000_0000, pad_bits - p0);
    summarize;
  end
endmodule // tb_top
